// ===== rtl/pio_regs.vh
// register map, field codes, reset values and timing counts of the port block
`ifndef PIO_REGS_VH
`define PIO_REGS_VH

// byte offsets
`define PIO_OFS_DATA_A    8'h00
`define PIO_OFS_DATA_B    8'h04
`define PIO_OFS_DATA_C    8'h08
`define PIO_OFS_DATA_E    8'h0C
`define PIO_OFS_DATA_0    8'h10
`define PIO_OFS_CFG_A     8'h14
`define PIO_OFS_CFG_B     8'h18
`define PIO_OFS_CFG_C     8'h1C
`define PIO_OFS_CFG_E     8'h20
`define PIO_OFS_CFG_0     8'h24
`define PIO_OFS_IRQ_EN    8'h28
`define PIO_OFS_IRQ_FLAG  8'h2C
`define PIO_OFS_ALT       8'h30
`define PIO_OFS_STATUS    8'h34

// per-bit configuration nibble: bit 2 direction, bits 1:0 mode
`define PIO_CFG_DIR       2
`define PIO_IN_HIZ        2'h0
`define PIO_IN_PULLUP     2'h1
`define PIO_IN_PULLDN     2'h2
`define PIO_OUT_HIZ       2'h0
`define PIO_OUT_PCH_OD    2'h1
`define PIO_OUT_NCH_OD    2'h2
`define PIO_OUT_CMOS      2'h3

// irq enable fields
`define PIO_IEN_TIMER_LSB 0
`define PIO_IEN_SER_LSB   4
`define PIO_IEN_IN_LSB    8
// irq flag bits
`define PIO_FLG_TIMER     0
`define PIO_FLG_SER       1
`define PIO_FLG_SINGLE    2
`define PIO_FLG_IN        3
// alternate function fields
`define PIO_ALT_B_LSB     0
`define PIO_ALT_C_LSB     4
`define PIO_ALT_E_LSB     8
`define PIO_ALT_TXC_MST   12
`define PIO_ALT_RXC_MST   13
`define PIO_ALT_SCK_MST   14

// reset values
`define PIO_RST_DATA      4'h0
`define PIO_RST_CFG       16'h1111
`define PIO_RST_CFG0      8'h55
`define PIO_RST_IRQ_EN    12'h000
`define PIO_RST_ALT       15'h0000

// machine cycles per access class
`define PIO_MC_PORT_WR    2'd1
`define PIO_MC_PORT_RD    2'd2
`define PIO_MC_FLAG_WR    2'd3
`define PIO_MC_OTHER      2'd1

`endif

// ===== rtl/pio_sync.v
// two-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module pio_sync #(
  parameter W = 20
) (
  // clock and reset
  input  wire         hclk,
  input  wire         hresetn,
  // levels
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);

  reg [W-1:0] meta_r;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      // idle level of the pulled-up pins, so no false change follows reset
      meta_r   <= {W{1'b1}};
      sync_out <= {W{1'b1}};
    end
    else
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// ===== rtl/pio_pad.v
// pad drive decode for one 4-bit port from its configuration and data
`timescale 1ns/1ps
`include "pio_regs.vh"
module pio_pad (
  // configuration and data
  input  wire [15:0] cfg,
  input  wire [3:0]  dat,
  // alternate function drive
  input  wire [3:0]  alt_drv,
  input  wire [3:0]  alt_val,
  // pad controls
  output reg  [3:0]  pad_out,
  output reg  [3:0]  pad_oe,
  output reg  [3:0]  pull_up,
  output reg  [3:0]  pull_dn
);

  integer i;
  reg [1:0] mode;
  reg       dir;
  reg       val;

  always @*
  begin
    pad_out = 4'h0;
    pad_oe  = 4'h0;
    pull_up = 4'h0;
    pull_dn = 4'h0;
    mode    = 2'h0;
    dir     = 1'b0;
    val     = 1'b0;
    for (i = 0; i < 4; i = i + 1)
    begin
      mode = cfg[4*i +: 2];
      dir  = cfg[4*i + `PIO_CFG_DIR];
      val  = alt_drv[i] ? alt_val[i] : dat[i];
      if (alt_drv[i])
      begin
        pad_out[i] = val;
        pad_oe[i]  = 1'b1;
      end
      else if (dir)
      begin
        case (mode)
          `PIO_OUT_PCH_OD:
          begin
            pad_out[i] = 1'b1;
            pad_oe[i]  = val;
          end
          `PIO_OUT_NCH_OD:
          begin
            pad_out[i] = 1'b0;
            pad_oe[i]  = ~val;
          end
          `PIO_OUT_CMOS:
          begin
            pad_out[i] = val;
            pad_oe[i]  = 1'b1;
          end
          default:
          begin
            pad_out[i] = 1'b0;
            pad_oe[i]  = 1'b0;
          end
        endcase
      end
      else
      begin
        pull_up[i] = (mode == `PIO_IN_PULLUP);
        pull_dn[i] = (mode == `PIO_IN_PULLDN);
      end
    end
  end

endmodule

// ===== rtl/pio_top.v
// port i/o block: machine-cycle sequencer, port pins, change interrupts, pin functions
// Behaviour
// - state advances every undivided system clock
// - machine cycle is first then second state
// - each state lasts exactly one clock
// - accesses take one, two or three machine cycles
// - port write reaches pins as second state ends
// - read samples in first state, loads next cycle
// - sample is one only if high throughout
// - change flag set at first state start
// - accepted interrupt starts routine next machine cycle
// - input bits select pull-up, pull-down or hiz
// - output bits select pch, nch, cmos, hiz
// - a level change on an enabled pin raises its group event
// - per-pin enables for timer, serial, input groups
// - timer port bits 0,1 feed capture triggers
// - timer port bits 0,1 output overflow flags
// - timer port bits 2,3 supply timer clocks
// - transmit clock output when master, else input
// - receive clock output when master, else input
// - shifter clock output when master, else input
`timescale 1ns/1ps
`include "pio_regs.vh"
module pio_top (
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg  [31:0] hrdata,
  output reg         hresp,
  // pin levels
  input  wire [3:0]  port_a_in,
  input  wire [3:0]  capture_timer_port_in,
  input  wire [3:0]  serial_irq_port_in,
  input  wire [3:0]  port_e_in,
  input  wire [3:0]  input_irq_port_in,
  // pin drive
  output reg  [3:0]  port_a_out,
  output reg  [3:0]  port_a_oe,
  output reg  [3:0]  port_a_pu,
  output reg  [3:0]  port_a_pd,
  output reg  [3:0]  capture_timer_port_out,
  output reg  [3:0]  capture_timer_port_oe,
  output reg  [3:0]  capture_timer_port_pu,
  output reg  [3:0]  capture_timer_port_pd,
  output reg  [3:0]  serial_irq_port_out,
  output reg  [3:0]  serial_irq_port_oe,
  output reg  [3:0]  serial_irq_port_pu,
  output reg  [3:0]  serial_irq_port_pd,
  output reg  [3:0]  port_e_out,
  output reg  [3:0]  port_e_oe,
  output reg  [3:0]  port_e_pu,
  output reg  [3:0]  port_e_pd,
  output reg  [3:0]  input_irq_port_pu,
  output reg  [3:0]  input_irq_port_pd,
  // timer side
  input  wire        timer_zero_overflow_out,
  input  wire        timer_one_overflow_out,
  output reg         timer_zero_capture_in,
  output reg         timer_one_capture_in,
  output reg         timer_zero_two_ext_clock,
  output reg         timer_one_three_ext_clock,
  // serial and shifter side
  input  wire        serial_tx_data,
  input  wire        serial_tx_clock_drv,
  input  wire        serial_rx_clock_drv,
  input  wire        shifter_serial_out,
  input  wire        shifter_clock_drv,
  output reg         serial_rx_data,
  output reg         serial_transmit_clock,
  output reg         serial_receive_clock,
  output reg         shifter_serial_in,
  output reg         shifter_clock,
  // interrupt side
  input  wire        irq_accept,
  output reg         ext_irq_group_timer_port,
  output reg         ext_irq_group_serial_port,
  output reg         ext_irq_single_pin,
  output reg         ext_irq_group_input_port,
  output reg         routine_start,
  // machine cycle timing
  output reg         second_state
);

  localparam FIRST  = 1'b0;
  localparam SECOND = 1'b1;

  localparam ST_IDLE  = 2'd0;
  localparam ST_ALIGN = 2'd1;
  localparam ST_EXEC  = 2'd2;
  localparam ST_DONE  = 2'd3;

  function is_port_data;
    input [7:0] a;
    begin
      is_port_data = (a == `PIO_OFS_DATA_A) || (a == `PIO_OFS_DATA_B) ||
                     (a == `PIO_OFS_DATA_C) || (a == `PIO_OFS_DATA_E) ||
                     (a == `PIO_OFS_DATA_0);
    end
  endfunction

  function [3:0] pin_sel;
    input [7:0]  a;
    input [19:0] p;
    begin
      case (a)
        `PIO_OFS_DATA_A: pin_sel = p[3:0];
        `PIO_OFS_DATA_B: pin_sel = p[7:4];
        `PIO_OFS_DATA_C: pin_sel = p[11:8];
        `PIO_OFS_DATA_E: pin_sel = p[15:12];
        `PIO_OFS_DATA_0: pin_sel = p[19:16];
        default:         pin_sel = 4'h0;
      endcase
    end
  endfunction

  // synchronised pins: {p0, e, c, b, a}
  wire [19:0] pin_s;
  pio_sync #(.W(20)) u_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in ({input_irq_port_in, port_e_in, serial_irq_port_in,
                capture_timer_port_in, port_a_in}),
    .sync_out (pin_s)
  );

  reg        phase_r;
  reg [1:0]  st_r;
  reg [1:0]  mc_cnt_r;
  reg [1:0]  mc_len_r;
  reg [7:0]  addr_r;
  reg        wr_r;
  reg [19:0] pin_d_r;
  reg [3:0]  capt_r;
  reg [3:0]  acc_r;
  reg [3:0]  dat_a_r;
  reg [3:0]  dat_b_r;
  reg [3:0]  dat_c_r;
  reg [3:0]  dat_e_r;
  reg [15:0] cfg_a_r;
  reg [15:0] cfg_b_r;
  reg [15:0] cfg_c_r;
  reg [15:0] cfg_e_r;
  reg [7:0]  cfg_0_r;
  reg [11:0] ien_r;
  reg [3:0]  flag_r;
  reg [3:0]  pend_r;
  reg [14:0] alt_r;
  reg        accepted_r;

  wire       take    = hsel && htrans[1] && hready && (st_r == ST_IDLE || st_r == ST_DONE);
  wire       mc_last = (mc_cnt_r == mc_len_r - 2'd1);
  wire       step    = (st_r == ST_EXEC) && (phase_r == SECOND);
  wire       wr_port = (st_r == ST_EXEC) && (phase_r == FIRST) && wr_r && (mc_cnt_r == 2'd0);
  wire       wr_end  = step && wr_r && mc_last;

  // machine-cycle phase: one state per undivided clock
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      phase_r <= FIRST;
    else
      phase_r <= ~phase_r;
  end

  // access sequencer
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r      <= ST_IDLE;
      mc_cnt_r  <= 2'd0;
      mc_len_r  <= `PIO_MC_OTHER;
      addr_r    <= 8'h00;
      wr_r      <= 1'b0;
      hreadyout <= 1'b1;
    end
    else
    begin
      case (st_r)
        ST_IDLE, ST_DONE:
        begin
          hreadyout <= 1'b1;
          st_r      <= ST_IDLE;
          if (take)
          begin
            addr_r    <= {haddr[7:2], 2'b00};
            wr_r      <= hwrite;
            hreadyout <= 1'b0;
            st_r      <= ST_ALIGN;
            mc_cnt_r  <= 2'd0;
            if (is_port_data(haddr))
              mc_len_r <= hwrite ? `PIO_MC_PORT_WR : `PIO_MC_PORT_RD;
            else if (hwrite && ({haddr[7:2], 2'b00} == `PIO_OFS_IRQ_FLAG))
              mc_len_r <= `PIO_MC_FLAG_WR;
            else
              mc_len_r <= `PIO_MC_OTHER;
          end
        end
        ST_ALIGN:
        begin
          // begin the first machine cycle on a first state
          if (phase_r == SECOND)
            st_r <= ST_EXEC;
        end
        ST_EXEC:
        begin
          if (phase_r == SECOND)
          begin
            if (mc_last)
            begin
              st_r      <= ST_DONE;
              hreadyout <= 1'b1;
            end
            else
              mc_cnt_r <= mc_cnt_r + 2'd1;
          end
        end
        default:
          st_r <= ST_IDLE;
      endcase
    end
  end

  // port read: sample in first state, load accumulator next machine cycle
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_d_r <= 20'hFFFFF;
      capt_r  <= 4'h0;
      acc_r   <= 4'h0;
    end
    else
    begin
      pin_d_r <= pin_s;
      if (st_r == ST_EXEC && phase_r == FIRST && mc_cnt_r == 2'd0)
        capt_r <= pin_sel(addr_r, pin_s) & pin_sel(addr_r, pin_d_r);
      if (st_r == ST_EXEC && phase_r == FIRST && mc_cnt_r == 2'd1 && !wr_r)
        acc_r <= capt_r;
    end
  end

  // read data
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h00000000;
      hresp  <= 1'b0;
    end
    else if (step && mc_last && !wr_r)
    begin
      case (addr_r)
        `PIO_OFS_DATA_A,
        `PIO_OFS_DATA_B,
        `PIO_OFS_DATA_C,
        `PIO_OFS_DATA_E,
        `PIO_OFS_DATA_0:   hrdata <= {28'h0000000, acc_r};
        `PIO_OFS_CFG_A:    hrdata <= {16'h0000, cfg_a_r};
        `PIO_OFS_CFG_B:    hrdata <= {16'h0000, cfg_b_r};
        `PIO_OFS_CFG_C:    hrdata <= {16'h0000, cfg_c_r};
        `PIO_OFS_CFG_E:    hrdata <= {16'h0000, cfg_e_r};
        `PIO_OFS_CFG_0:    hrdata <= {24'h000000, cfg_0_r};
        `PIO_OFS_IRQ_EN:   hrdata <= {20'h00000, ien_r};
        `PIO_OFS_IRQ_FLAG: hrdata <= {28'h0000000, flag_r};
        `PIO_OFS_ALT:      hrdata <= {17'h00000, alt_r};
        `PIO_OFS_STATUS:   hrdata <= {16'h0000, dat_e_r, dat_c_r, dat_b_r, dat_a_r};
        default:           hrdata <= 32'h00000000;
      endcase
    end
  end

  // port latches and configuration
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dat_a_r <= `PIO_RST_DATA;
      dat_b_r <= `PIO_RST_DATA;
      dat_c_r <= `PIO_RST_DATA;
      dat_e_r <= `PIO_RST_DATA;
      cfg_a_r <= `PIO_RST_CFG;
      cfg_b_r <= `PIO_RST_CFG;
      cfg_c_r <= `PIO_RST_CFG;
      cfg_e_r <= `PIO_RST_CFG;
      cfg_0_r <= `PIO_RST_CFG0;
      ien_r   <= `PIO_RST_IRQ_EN;
      alt_r   <= `PIO_RST_ALT;
    end
    else if (wr_port)
    begin
      // latched in the first state so the registered pins move as the second ends
      case (addr_r)
        `PIO_OFS_DATA_A: dat_a_r <= hwdata[3:0];
        `PIO_OFS_DATA_B: dat_b_r <= hwdata[3:0];
        `PIO_OFS_DATA_C: dat_c_r <= hwdata[3:0];
        `PIO_OFS_DATA_E: dat_e_r <= hwdata[3:0];
        `PIO_OFS_CFG_A:  cfg_a_r <= hwdata[15:0];
        `PIO_OFS_CFG_B:  cfg_b_r <= hwdata[15:0];
        `PIO_OFS_CFG_C:  cfg_c_r <= hwdata[15:0];
        `PIO_OFS_CFG_E:  cfg_e_r <= hwdata[15:0];
        `PIO_OFS_CFG_0:  cfg_0_r <= hwdata[7:0];
        `PIO_OFS_IRQ_EN: ien_r   <= hwdata[11:0];
        `PIO_OFS_ALT:    alt_r   <= hwdata[14:0];
        default:         alt_r   <= alt_r;
      endcase
    end
  end

  // level-change events per group, masked per pin; single-pin event unmasked
  wire [19:0] chg = pin_s ^ pin_d_r;
  wire [3:0]  ev;
  assign ev[`PIO_FLG_TIMER]  = |(chg[7:4] & ien_r[`PIO_IEN_TIMER_LSB +: 4]);
  assign ev[`PIO_FLG_SER]    = |(chg[11:8] & ien_r[`PIO_IEN_SER_LSB +: 4]);
  assign ev[`PIO_FLG_SINGLE] = chg[15];
  assign ev[`PIO_FLG_IN]     = |(chg[19:16] & ien_r[`PIO_IEN_IN_LSB +: 4]);

  wire [3:0] flag_clr = wr_end && (addr_r == `PIO_OFS_IRQ_FLAG) ? hwdata[3:0] : 4'h0;
  wire [3:0] flag_set = (phase_r == SECOND) ? (pend_r | ev) : 4'h0;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pend_r     <= 4'h0;
      flag_r     <= 4'h0;
      accepted_r <= 1'b0;
    end
    else
    begin
      // events gather and post into the flags as the first state opens
      pend_r     <= (phase_r == SECOND) ? 4'h0 : (pend_r | ev);
      flag_r     <= (flag_r & ~flag_clr) | flag_set;
      accepted_r <= (phase_r == SECOND) ? 1'b0 : (accepted_r | irq_accept);
    end
  end

  // alternate pin drive
  wire [3:0] alt_b = alt_r[`PIO_ALT_B_LSB +: 4];
  wire [3:0] alt_c = alt_r[`PIO_ALT_C_LSB +: 4];
  wire [3:0] alt_e = alt_r[`PIO_ALT_E_LSB +: 4];
  wire [3:0] drv_b = alt_b & 4'h3;
  wire [3:0] val_b = {2'b00, timer_one_overflow_out, timer_zero_overflow_out};
  wire [3:0] drv_c = alt_c & {1'b1, alt_r[`PIO_ALT_RXC_MST], alt_r[`PIO_ALT_TXC_MST], 1'b0};
  wire [3:0] val_c = {serial_tx_data, serial_rx_clock_drv, serial_tx_clock_drv, 1'b0};
  wire [3:0] drv_e = alt_e & {1'b0, alt_r[`PIO_ALT_SCK_MST], 1'b1, 1'b0};
  wire [3:0] val_e = {1'b0, shifter_clock_drv, shifter_serial_out, 1'b0};

  wire [3:0] a_o, a_oe, a_pu, a_pd, b_o, b_oe, b_pu, b_pd;
  wire [3:0] c_o, c_oe, c_pu, c_pd, e_o, e_oe, e_pu, e_pd;

  pio_pad u_pad_a (.cfg(cfg_a_r), .dat(dat_a_r), .alt_drv(4'h0), .alt_val(4'h0),
                   .pad_out(a_o), .pad_oe(a_oe), .pull_up(a_pu), .pull_dn(a_pd));
  pio_pad u_pad_b (.cfg(cfg_b_r), .dat(dat_b_r), .alt_drv(drv_b), .alt_val(val_b),
                   .pad_out(b_o), .pad_oe(b_oe), .pull_up(b_pu), .pull_dn(b_pd));
  pio_pad u_pad_c (.cfg(cfg_c_r), .dat(dat_c_r), .alt_drv(drv_c), .alt_val(val_c),
                   .pad_out(c_o), .pad_oe(c_oe), .pull_up(c_pu), .pull_dn(c_pd));
  pio_pad u_pad_e (.cfg(cfg_e_r), .dat(dat_e_r), .alt_drv(drv_e), .alt_val(val_e),
                   .pad_out(e_o), .pad_oe(e_oe), .pull_up(e_pu), .pull_dn(e_pd));

  // registered pin drive
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      port_a_out             <= 4'h0;
      port_a_oe              <= 4'h0;
      port_a_pu              <= 4'hF;
      port_a_pd              <= 4'h0;
      capture_timer_port_out <= 4'h0;
      capture_timer_port_oe  <= 4'h0;
      capture_timer_port_pu  <= 4'hF;
      capture_timer_port_pd  <= 4'h0;
      serial_irq_port_out    <= 4'h0;
      serial_irq_port_oe     <= 4'h0;
      serial_irq_port_pu     <= 4'hF;
      serial_irq_port_pd     <= 4'h0;
      port_e_out             <= 4'h0;
      port_e_oe              <= 4'h0;
      port_e_pu              <= 4'hF;
      port_e_pd              <= 4'h0;
      input_irq_port_pu      <= 4'hF;
      input_irq_port_pd      <= 4'h0;
    end
    else
    begin
      port_a_out             <= a_o;
      port_a_oe              <= a_oe;
      port_a_pu              <= a_pu;
      port_a_pd              <= a_pd;
      capture_timer_port_out <= b_o;
      capture_timer_port_oe  <= b_oe;
      capture_timer_port_pu  <= b_pu;
      capture_timer_port_pd  <= b_pd;
      serial_irq_port_out    <= c_o;
      serial_irq_port_oe     <= c_oe;
      serial_irq_port_pu     <= c_pu;
      serial_irq_port_pd     <= c_pd;
      port_e_out             <= e_o;
      port_e_oe              <= e_oe;
      port_e_pu              <= e_pu;
      port_e_pd              <= e_pd;
      input_irq_port_pu      <= {cfg_0_r[6] , cfg_0_r[4], cfg_0_r[2], cfg_0_r[0]};
      input_irq_port_pd      <= {cfg_0_r[7] , cfg_0_r[5], cfg_0_r[3], cfg_0_r[1]};
    end
  end

  // peripheral-facing outputs and interrupt requests
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      timer_zero_capture_in     <= 1'b0;
      timer_one_capture_in      <= 1'b0;
      timer_zero_two_ext_clock  <= 1'b0;
      timer_one_three_ext_clock <= 1'b0;
      serial_rx_data            <= 1'b0;
      serial_transmit_clock     <= 1'b0;
      serial_receive_clock      <= 1'b0;
      shifter_serial_in         <= 1'b0;
      shifter_clock             <= 1'b0;
      ext_irq_group_timer_port  <= 1'b0;
      ext_irq_group_serial_port <= 1'b0;
      ext_irq_single_pin        <= 1'b0;
      ext_irq_group_input_port  <= 1'b0;
      routine_start             <= 1'b0;
      second_state              <= 1'b0;
    end
    else
    begin
      timer_zero_capture_in     <= pin_s[4];
      timer_one_capture_in      <= pin_s[5];
      timer_zero_two_ext_clock  <= pin_s[6];
      timer_one_three_ext_clock <= pin_s[7];
      serial_rx_data            <= pin_s[8];
      serial_transmit_clock     <= alt_r[`PIO_ALT_TXC_MST] ? serial_tx_clock_drv : pin_s[9];
      serial_receive_clock      <= alt_r[`PIO_ALT_RXC_MST] ? serial_rx_clock_drv : pin_s[10];
      shifter_serial_in         <= pin_s[12];
      shifter_clock             <= alt_r[`PIO_ALT_SCK_MST] ? shifter_clock_drv : pin_s[14];
      ext_irq_group_timer_port  <= flag_r[`PIO_FLG_TIMER];
      ext_irq_group_serial_port <= flag_r[`PIO_FLG_SER];
      ext_irq_single_pin        <= flag_r[`PIO_FLG_SINGLE];
      ext_irq_group_input_port  <= flag_r[`PIO_FLG_IN];
      routine_start             <= (phase_r == SECOND) && (accepted_r || irq_accept);
      second_state              <= ~phase_r;
    end
  end

endmodule

// ===== bench/pio_top_assertions.sv
// concurrent checks on pins and bus handshake
`timescale 1ns/1ps
module pio_chk (
  // clock and reset
  input wire       hclk,
  input wire       hresetn,
  // observed
  input wire       hreadyout,
  input wire       second_state,
  input wire       irq_accept,
  input wire       routine_start,
  input wire [3:0] port_a_out,
  input wire [3:0] capture_timer_port_in,
  input wire       timer_zero_capture_in,
  input wire       timer_one_capture_in,
  input wire       timer_zero_two_ext_clock,
  input wire       timer_one_three_ext_clock,
  input wire       ext_irq_group_input_port,
  input wire       ext_irq_single_pin
);
  default clocking @(posedge hclk); endclocking
  logic rst_q;
  always @(posedge hclk) rst_q <= hresetn;
  default disable iff (!hresetn || !rst_q);
  sequence s_quiet;
    $stable(capture_timer_port_in) [*5];
  endsequence
  sequence s_busy;
    !hreadyout [*3] ##[1:6] hreadyout;
  endsequence
  property p_first; !second_state |=> second_state; endproperty
  a_first: assert property (p_first) else $error("no second state");
  property p_second; second_state |=> !second_state; endproperty
  a_second: assert property (p_second) else $error("state too long");
  property p_cycles; $fell(hreadyout) |-> s_busy; endproperty
  a_cycles: assert property (p_cycles) else $error("bad access length");
  property p_wr; $changed(port_a_out) |-> $past(second_state) && hreadyout; endproperty
  a_wr: assert property (p_wr) else $error("port out moved off a write");
  property p_rtn; irq_accept |-> ##[1:2] (routine_start && !second_state); endproperty
  a_rtn: assert property (p_rtn) else $error("routine start late");
  property p_irq;
    $rose(ext_irq_group_input_port) || $rose(ext_irq_single_pin) |-> second_state;
  endproperty
  a_irq: assert property (p_irq) else $error("request off first state");
  property p_cap;
    s_quiet |-> {timer_one_capture_in, timer_zero_capture_in} == capture_timer_port_in[1:0];
  endproperty
  a_cap: assert property (p_cap) else $error("capture not from pin");
  property p_clk;
    s_quiet |->
      {timer_one_three_ext_clock, timer_zero_two_ext_clock} == capture_timer_port_in[3:2];
  endproperty
  a_clk: assert property (p_clk) else $error("timer clock not from pin");
endmodule
bind pio_top pio_chk pio_chk_i (.*);

// ===== bench/pio_pin_model.sv
// pin model: pad drive, pulls and outside sources
`timescale 1ns/1ps
module pio_pin_model (
  // clock
  input  wire        clk,
  // pad controls
  input  wire  [3:0] out,
  input  wire  [3:0] oe,
  input  wire  [3:0] pu,
  input  wire  [3:0] pd,
  // outside source
  input  wire  [3:0] den,
  input  wire  [3:0] dval,
  // resolved level
  output logic [3:0] lvl
);
  logic [3:0] flt_r = 4'hA;
  always @(posedge clk)
    flt_r <= ~flt_r;
  always_comb
    for (int i = 0; i < 4; i++)
      lvl[i] = oe[i] ? out[i] : den[i] ? dval[i] : pu[i] ? 1'b1 : pd[i] ? 1'b0 : flt_r[i];
endmodule

// ===== bench/pio_top_tb_top.sv
// self-checking bench for the port block
`timescale 1ns/1ps
`include "pio_regs.vh"
module pio_top_tb_top;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, irq_accept = 0, rd_ph = 0;
  logic        hreadyout, hresp, routine_start, second_state;
  wire         hready = hreadyout;
  logic [7:0]  haddr = 0;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 0, hrdata, seed = 32111, exp_q[$];
  logic [19:0] den = 20'hFFFFF, dval = 20'hFFFFF;
  logic [6:0]  misc = 0;
  logic [3:0]  port_a_in, capture_timer_port_in, serial_irq_port_in, port_e_in, input_irq_port_in;
  logic [3:0]  port_a_out, port_a_oe, port_a_pu, port_a_pd, input_irq_port_pu, input_irq_port_pd;
  logic [3:0]  capture_timer_port_out, capture_timer_port_oe, capture_timer_port_pu;
  logic [3:0]  capture_timer_port_pd, serial_irq_port_out, serial_irq_port_oe;
  logic [3:0]  serial_irq_port_pu, serial_irq_port_pd, port_e_out, port_e_oe, port_e_pu, port_e_pd;
  logic        timer_zero_capture_in, timer_one_capture_in, timer_zero_two_ext_clock;
  logic        timer_one_three_ext_clock, serial_rx_data, serial_transmit_clock;
  logic        serial_receive_clock, shifter_serial_in, shifter_clock, ext_irq_single_pin;
  logic        ext_irq_group_timer_port, ext_irq_group_serial_port, ext_irq_group_input_port;
  wire         timer_zero_overflow_out, timer_one_overflow_out, serial_tx_data;
  wire         serial_tx_clock_drv, serial_rx_clock_drv, shifter_serial_out, shifter_clock_drv;
  int          mismatches = 0, cmp_count = 0, m;
  assign {timer_zero_overflow_out, timer_one_overflow_out, serial_tx_data, serial_tx_clock_drv,
    serial_rx_clock_drv, shifter_serial_out, shifter_clock_drv} = misc;
  pio_top pio_top_i (.*);
  pio_pin_model pm_a (.clk(hclk), .out(port_a_out), .oe(port_a_oe), .pu(port_a_pu),
    .pd(port_a_pd), .den(den[3:0]), .dval(dval[3:0]), .lvl(port_a_in));
  pio_pin_model pm_b (.clk(hclk), .out(capture_timer_port_out), .oe(capture_timer_port_oe),
    .pu(capture_timer_port_pu), .pd(capture_timer_port_pd), .den(den[7:4]), .dval(dval[7:4]),
    .lvl(capture_timer_port_in));
  pio_pin_model pm_c (.clk(hclk), .out(serial_irq_port_out), .oe(serial_irq_port_oe),
    .pu(serial_irq_port_pu), .pd(serial_irq_port_pd), .den(den[11:8]), .dval(dval[11:8]),
    .lvl(serial_irq_port_in));
  pio_pin_model pm_e (.clk(hclk), .out(port_e_out), .oe(port_e_oe), .pu(port_e_pu),
    .pd(port_e_pd), .den(den[15:12]), .dval(dval[15:12]), .lvl(port_e_in));
  pio_pin_model pm_0 (.clk(hclk), .out(4'h0), .oe(4'h0), .pu(input_irq_port_pu),
    .pd(input_irq_port_pd), .den(den[19:16]), .dval(dval[19:16]), .lvl(input_irq_port_in));
  always #12.5 hclk = ~hclk;
  function automatic [31:0] lfsr(input [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task results;
    if (mismatches == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] s);
    cmp_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wt;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    if (n >= 40)
    begin
      mismatches++;
      results;
    end
  endtask
  task xfer(input w, input [7:0] a, input [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wt;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rd(input [7:0] a, input [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask
  // read data against the oldest note
  always @(posedge hclk)
    if (hreadyout === 1'b1)
    begin
      chk("hresp", 32'h0, hresp);
      if (rd_ph)
        chk("hrdata", exp_q.pop_front(), hrdata);
      rd_ph <= hsel & htrans[1] & !hwrite;
    end
  initial
  begin
    dval <= seed[19:0];
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("pu_a", 32'hF, port_a_pu);
    rd(`PIO_OFS_CFG_A, 32'h1111);
    rd(`PIO_OFS_IRQ_EN, 32'h0);
    rd(8'h3C, 32'h0);
    for (m = 0; m < 3; m++)
    begin
      wr(`PIO_OFS_CFG_A, 32'h1111 * m);
      repeat (2) @(posedge hclk);
      chk("pu_a", {4{m == 1}}, port_a_pu);
      chk("pd_a", {4{m == 2}}, port_a_pd);
    end
    for (m = 0; m < 4; m += 3)
    begin
      seed = lfsr(seed);
      wr(`PIO_OFS_DATA_A, seed);
      wr(`PIO_OFS_CFG_A, 32'h1111 * (4 + m));
      repeat (2) @(posedge hclk);
      chk("oe_a", {4{m == 3}}, port_a_oe);
      chk("out_a", seed[3:0] & {4{m == 3}}, port_a_out);
    end
    wr(`PIO_OFS_CFG_A, 32'h0);
    dval[3:0] <= seed[7:4];
    repeat (4) @(posedge hclk);
    rd(`PIO_OFS_DATA_A, seed[7:4]);
    wr(`PIO_OFS_IRQ_EN, 32'h100);
    wr(`PIO_OFS_IRQ_FLAG, 32'hF);
    dval[17] <= ~dval[17];
    repeat (8) @(posedge hclk);
    chk("irq_in", 32'h0, ext_irq_group_input_port);
    dval[16] <= ~dval[16];
    dval[15] <= ~dval[15];
    repeat (8) @(posedge hclk);
    chk("irq_in", 32'h1, ext_irq_group_input_port);
    chk("irq_pin", 32'h1, ext_irq_single_pin);
    rd(`PIO_OFS_IRQ_FLAG, 32'hC);
    wr(`PIO_OFS_IRQ_FLAG, 32'hF);
    rd(`PIO_OFS_IRQ_FLAG, 32'h0);
    irq_accept <= 1'b1;
    @(posedge hclk);
    irq_accept <= 1'b0;
    wr(`PIO_OFS_ALT, 32'h7003);
    misc <= seed[14:8];
    repeat (3) @(posedge hclk);
    chk("txc", serial_tx_clock_drv, serial_transmit_clock);
    chk("rxc", serial_rx_clock_drv, serial_receive_clock);
    chk("sck", shifter_clock_drv, shifter_clock);
    chk("ovf", {misc[5], misc[6]}, capture_timer_port_out[1:0]);
    wr(`PIO_OFS_ALT, 32'h0);
    dval[14:8] <= seed[6:0];
    repeat (5) @(posedge hclk);
    chk("txc", dval[9], serial_transmit_clock);
    chk("rxc", dval[10], serial_receive_clock);
    chk("sck", dval[14], shifter_clock);
    results;
  end
endmodule
